// ==== hdl/tp_media_status_indicators.sv ====
// media mode selection, activity stretching, polarity and link indicators
// assumes straps and activity pulses synchronous to clk; AXI4-Lite master on one clock
// How it works
// [R1] codec bypass strap at 1 turns the internal line codec off, at 0 on.
// [R2] dual-function codec pins take their alternate meaning when the bypass strap is 1.
// [R3] media port select at 1 routes the codec to the attachment unit, at 0 to twisted pair.
// [R4] each transmit drives the low-active transmit indicator for about 50 ms.
// [R5] each detected receive drives the low-active receive indicator for about 50 ms.
// [R6] each collision drives the low-active collision indicator for about 50 ms.
// [R7] the polarity indicator asserts after seven reversed link pulses or three reversed packets in a row.
// [R8] the link indicator is off in attachment unit mode or when testing is on and the link is bad.
// [R9] the link indicator is on in twisted pair mode when the link is good or testing is off.
// [R10] link disable strap at 0 stops link pulse generation and integrity checking.
// [R11] reduced squelch strap at 1 selects the lower squelch threshold.
// [R12] a new event during an active stretch restarts its full period.
// [R13] a normal-polarity pulse clears the reversed pulse count, a normal-polarity packet the reversed packet count.
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "tp_media_cfg.svh"

module activity_stretch #(
  parameter int STRETCH = `STRETCH_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // event in, stretched level out
  input wire logic trigger,
  output logic active
);
  logic [`STRETCH_W-1:0] count_r;
  localparam logic [`STRETCH_W-1:0] RELOAD = `STRETCH_W'(STRETCH - 1);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_r <= '0;
      active <= 1'b0;
    end else if (trigger) begin
      count_r <= RELOAD; // [R12]
      active <= 1'b1;
    end else if (count_r != '0) begin
      count_r <= count_r - `STRETCH_W'(1);
    end else begin
      active <= 1'b0;
    end
  end

  stretch_load_a: assert property (@(posedge clk) disable iff (!rstn) // [R12]
    trigger |=> active && count_r == RELOAD) else $error("stretch not reloaded");
  stretch_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(active) |-> $past(count_r) == '0 && !$past(trigger))
    else $error("stretch ended early");
endmodule // activity_stretch

module tp_media_status_indicators
  import tp_media_pkg::*;
#(
  parameter int STRETCH_CYCLES = `STRETCH_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // straps and line state
  input wire strap_type straps,
  input wire activity_type activity,
  input wire logic linkIntegrityGood,
  // mode controls
  output mode_type mode,
  // indicators, low active
  output logic tx_activity_indicator_n,
  output logic rx_activity_indicator_n,
  output logic collision_indicator_n,
  output logic reversed_polarity_indicator_n,
  output logic link_good_indicator_n,
  // interrupt
  output logic irq,
  // AXI4-Lite write
  input wire logic [`ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [`ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  strap_type strap_r;
  logic txOn, rxOn, colOn;
  logic [2:0] pulseRevCount_r;
  logic [1:0] packetRevCount_r;
  logic polarityOn_r, linkOn_r, linkOn_nxt;
  logic [`EV_W-1:0] eventStatus_r, eventMask_r, eventSet;
  logic [`ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic awHeld_r, wHeld_r;
  logic doWrite;

  // straps are meant to be static; sampling them keeps every output on a flop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) strap_r <= '0;
    else strap_r <= straps;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode <= '0;
    end else begin
      mode.internalCodecEnable <= !strap_r.codecBypass; // [R1]
      mode.dualPinAlternate <= strap_r.codecBypass; // [R2]
      mode.auiRouted <= strap_r.mediaPortSelect; // [R3]
      mode.tpRouted <= !strap_r.mediaPortSelect; // [R3]
      mode.linkPulseGenEnable <= strap_r.linkTestDisable; // [R10]
      mode.integrityCheckEnable <= strap_r.linkTestDisable; // [R10]
      mode.lowSquelchSelect <= strap_r.reducedSquelch; // [R11]
    end
  end

  activity_stretch #(.STRETCH(STRETCH_CYCLES)) txStretch (
    .clk(clk), .rstn(rstn), .trigger(activity.txData), .active(txOn)); // [R4]
  activity_stretch #(.STRETCH(STRETCH_CYCLES)) rxStretch (
    .clk(clk), .rstn(rstn), .trigger(activity.rxData), .active(rxOn)); // [R5]
  activity_stretch #(.STRETCH(STRETCH_CYCLES)) colStretch (
    .clk(clk), .rstn(rstn), .trigger(activity.collision), .active(colOn)); // [R6]

  // stretch state is already a flop; the inversion stays out of the module
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_activity_indicator_n <= 1'b1;
      rx_activity_indicator_n <= 1'b1;
      collision_indicator_n <= 1'b1;
    end else begin
      tx_activity_indicator_n <= !(txOn || activity.txData); // [R4]
      rx_activity_indicator_n <= !(rxOn || activity.rxData); // [R5]
      collision_indicator_n <= !(colOn || activity.collision); // [R6]
    end
  end

  // polarity watch only counts while on twisted pair
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pulseRevCount_r <= '0;
      packetRevCount_r <= '0;
      polarityOn_r <= 1'b0;
    end else if (strap_r.mediaPortSelect) begin
      pulseRevCount_r <= '0;
      packetRevCount_r <= '0;
      polarityOn_r <= 1'b0;
    end else begin
      if (activity.pulseNormal) pulseRevCount_r <= '0; // [R13]
      else if (activity.pulseReversed && pulseRevCount_r != `REV_PULSE_LIMIT)
        pulseRevCount_r <= pulseRevCount_r + 3'h1;
      if (activity.packetNormal) packetRevCount_r <= '0; // [R13]
      else if (activity.packetReversed && packetRevCount_r != `REV_PACKET_LIMIT)
        packetRevCount_r <= packetRevCount_r + 2'h1;
      if (activity.pulseNormal || activity.packetNormal) polarityOn_r <= 1'b0; // [R13]
      else if (pulseRevCount_r == `REV_PULSE_LIMIT || packetRevCount_r == `REV_PACKET_LIMIT)
        polarityOn_r <= 1'b1; // [R7]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) reversed_polarity_indicator_n <= 1'b1;
    else reversed_polarity_indicator_n <= !polarityOn_r; // [R7]
  end

  // attachment unit mode wins over disabled testing
  always_comb begin
    linkOn_nxt = !strap_r.mediaPortSelect && (!strap_r.linkTestDisable || linkIntegrityGood); // [R8] [R9]
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      linkOn_r <= 1'b0;
      link_good_indicator_n <= 1'b1;
    end else begin
      linkOn_r <= linkOn_nxt;
      link_good_indicator_n <= !linkOn_r; // [R8] [R9]
    end
  end

  // sticky events, write one to clear; a set in the clear cycle survives
  always_comb begin
    eventSet = '0;
    eventSet[`EV_TX] = activity.txData;
    eventSet[`EV_RX] = activity.rxData;
    eventSet[`EV_COL] = activity.collision;
    eventSet[`EV_POL] = polarityOn_r && reversed_polarity_indicator_n;
    eventSet[`EV_LINK] = linkOn_r != linkOn_nxt;
  end

  assign doWrite = awHeld_r && wHeld_r && !bvalid;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eventStatus_r <= '0;
      eventMask_r <= `EVENT_MASK_RST;
    end else begin
      if (doWrite && awaddr_r == `REG_EVENT_STATUS && wstrb_r[0])
        eventStatus_r <= (eventStatus_r & ~wdata_r[`EV_W-1:0]) | eventSet;
      else
        eventStatus_r <= eventStatus_r | eventSet;
      if (doWrite && awaddr_r == `REG_EVENT_MASK && wstrb_r[0])
        eventMask_r <= wdata_r[`EV_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) irq <= 1'b0;
    else irq <= |(eventStatus_r & eventMask_r);
  end

  // write channel: address and data taken in either order, one at a time
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      awready <= !awHeld_r && !(awvalid && awready) && !bvalid;
      wready <= !wHeld_r && !(wvalid && wready) && !bvalid;
      if (awvalid && awready) begin
        awHeld_r <= 1'b1;
        awaddr_r <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp <= (awaddr_r == `REG_EVENT_STATUS || awaddr_r == `REG_EVENT_MASK ||
                  awaddr_r == `REG_MODE_STATUS) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `RESP_OKAY;
    end else begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp <= `RESP_OKAY;
        rdata <= '0;
        case (araddr)
          `REG_MODE_STATUS: begin
            rdata[`ST_STRAP_LSB +: 4] <= strap_r;
            rdata[`ST_IND_LSB +: 5] <= {linkOn_r, polarityOn_r, colOn, rxOn, txOn};
          end
          `REG_EVENT_STATUS: rdata[`EV_W-1:0] <= eventStatus_r;
          `REG_EVENT_MASK: rdata[`EV_W-1:0] <= eventMask_r;
          default: rresp <= `RESP_SLVERR;
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  sequence revPulseRun_s;
    !strap_r.mediaPortSelect && !activity.pulseNormal && !activity.packetNormal &&
      pulseRevCount_r == `REV_PULSE_LIMIT;
  endsequence

  codec_bypass_a: assert property (@(posedge clk) disable iff (!rstn) // [R1]
    rstn |=> mode.internalCodecEnable == !$past(strap_r.codecBypass))
    else $error("codec enable wrong");
  dual_pin_a: assert property (@(posedge clk) disable iff (!rstn) // [R2]
    rstn |=> mode.dualPinAlternate == $past(strap_r.codecBypass))
    else $error("pin meaning wrong");
  port_route_a: assert property (@(posedge clk) disable iff (!rstn) // [R3]
    mode.auiRouted != mode.tpRouted || $past(!rstn)) else $error("route not exclusive");
  tx_led_a: assert property (@(posedge clk) disable iff (!rstn) // [R4]
    activity.txData |=> !tx_activity_indicator_n [*2]) else $error("tx led not lit");
  rx_led_a: assert property (@(posedge clk) disable iff (!rstn) // [R5]
    activity.rxData |=> !rx_activity_indicator_n) else $error("rx led not lit");
  col_led_a: assert property (@(posedge clk) disable iff (!rstn) // [R6]
    activity.collision |=> !collision_indicator_n) else $error("col led not lit");
  polarity_set_a: assert property (@(posedge clk) disable iff (!rstn) // [R7]
    revPulseRun_s |-> ##2 !reversed_polarity_indicator_n) else $error("polarity not shown");
  polarity_clear_a: assert property (@(posedge clk) disable iff (!rstn) // [R13]
    activity.pulseNormal && !strap_r.mediaPortSelect |=> pulseRevCount_r == '0 ##1
      reversed_polarity_indicator_n) else $error("polarity count not cleared");
  link_off_a: assert property (@(posedge clk) disable iff (!rstn) // [R8]
    strap_r.mediaPortSelect [*3] |-> link_good_indicator_n) else $error("link lit in aui");
  link_on_a: assert property (@(posedge clk) disable iff (!rstn) // [R9]
    (!strap_r.mediaPortSelect && !strap_r.linkTestDisable) [*3] |-> !link_good_indicator_n)
    else $error("link dark with test off");
  link_test_a: assert property (@(posedge clk) disable iff (!rstn) // [R10]
    !strap_r.linkTestDisable |=> !mode.linkPulseGenEnable && !mode.integrityCheckEnable)
    else $error("link test still on");
  squelch_a: assert property (@(posedge clk) disable iff (!rstn) // [R11]
    strap_r.reducedSquelch |=> mode.lowSquelchSelect) else $error("squelch not reduced");
endmodule // tp_media_status_indicators
`default_nettype wire

// ==== hdl/tp_media_cfg.svh ====
// constants of the media status and indicator block
// assumes a 10 MHz clock and a 32-bit AXI4-Lite register port
`ifndef TP_MEDIA_CFG_SVH
`define TP_MEDIA_CFG_SVH

// timing
`define CLK_HZ 10000000
`define STRETCH_MS 50
`define STRETCH_CYCLES ((`STRETCH_MS * `CLK_HZ) / 1000)
`define STRETCH_W 19

// polarity thresholds
`define REV_PULSE_LIMIT 3'h7
`define REV_PACKET_LIMIT 2'h3

// register byte addresses
`define ADDR_W 4
`define REG_MODE_STATUS 4'h0
`define REG_EVENT_STATUS 4'h4
`define REG_EVENT_MASK 4'h8

// event bit positions
`define EV_W 5
`define EV_TX 0
`define EV_RX 1
`define EV_COL 2
`define EV_POL 3
`define EV_LINK 4

// status word field positions
`define ST_STRAP_LSB 0
`define ST_IND_LSB 4

// reset values and responses
`define EVENT_MASK_RST 5'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== hdl/tp_media_pkg.sv ====
// types shared by the media status and indicator block
// assumes nothing beyond the constants header
package tp_media_pkg;
  // static strap inputs as sampled
  typedef struct packed {
    logic reducedSquelch;
    logic linkTestDisable;
    logic mediaPortSelect;
    logic codecBypass;
  } strap_type;

  // mode controls handed to the codec and media paths
  typedef struct packed {
    logic lowSquelchSelect;
    logic integrityCheckEnable;
    logic linkPulseGenEnable;
    logic tpRouted;
    logic auiRouted;
    logic dualPinAlternate;
    logic internalCodecEnable;
  } mode_type;

  // line activity seen by the media side, one-cycle pulses
  typedef struct packed {
    logic packetReversed;
    logic packetNormal;
    logic pulseReversed;
    logic pulseNormal;
    logic collision;
    logic rxData;
    logic txData;
  } activity_type;
endpackage

// ==== tb/link_partner_model.sv ====
// twisted pair link partner: line activity pulses and link integrity level
// assumes the bench calls send and setGood; one clock, no reset of its own
`timescale 1ns/100ps
`default_nettype none

module link_partner_model
  import tp_media_pkg::*;
(
  // clock
  input wire logic clk,
  // line state seen by the block
  output activity_type activity,
  output logic linkIntegrityGood
);
  initial begin
    activity = '0;
    linkIntegrityGood = 1'b1;
  end

  // one-cycle pulse, then one idle cycle so each counts as a separate event
  task automatic send(input int idx, input int count);
    repeat (count) begin
      @(posedge clk);
      activity[idx] <= 1'b1;
      @(posedge clk);
      activity[idx] <= 1'b0;
    end
  endtask

  task automatic setGood(input logic good);
    @(posedge clk);
    linkIntegrityGood <= good;
  endtask
endmodule // link_partner_model

`default_nettype wire

// ==== tb/tp_media_status_indicators_test.sv ====
// self-checking bench of the media status and indicator block
// assumes the package and header compiled first; short stretch for run time
`timescale 1ns/100ps
`default_nettype none
`include "tp_media_cfg.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end

module tp_media_status_indicators_test
  import tp_media_pkg::*;
;
  localparam int STRETCH = 20;
  logic clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, good;
  logic txN, rxN, colN, polN, linkN;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  strap_type straps;
  activity_type act;
  mode_type mode;
  int n_fail, comparisons;
  wire logic [2:0] actN = {colN, rxN, txN};
  // rows: straps, link good, expected mode, expected link indicator
  logic [12:0] rows [6] = '{
    {4'b0100, 1'b1, 7'b0111001, 1'b0}, {4'b0100, 1'b0, 7'b0111001, 1'b1},
    {4'b0000, 1'b0, 7'b0001001, 1'b0}, {4'b0110, 1'b1, 7'b0110101, 1'b1},
    {4'b1101, 1'b1, 7'b1111010, 1'b0}, {4'b0010, 1'b1, 7'b0000101, 1'b1}};

  tp_media_status_indicators #(.STRETCH_CYCLES(STRETCH)) i_tp_media_status_indicators (
    .clk(clk), .rstn(rstn), .straps(straps), .activity(act), .linkIntegrityGood(good),
    .mode(mode), .tx_activity_indicator_n(txN), .rx_activity_indicator_n(rxN),
    .collision_indicator_n(colN), .reversed_polarity_indicator_n(polN),
    .link_good_indicator_n(linkN), .irq(irq), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  link_partner_model i_link_partner_model (.clk(clk), .activity(act), .linkIntegrityGood(good));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // each channel released at its own handshake edge
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    // idle edge so back to back reads never reassign rready in one step
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic finish_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // whole run is under 300 cycles
  initial begin
    #(6000 * 100);
    n_fail++;
    finish_test();
  end

  initial begin
    rstn = 1'b0;
    straps = strap_type'(4'b0100);
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    cyc(6);
    `CHK("reset indicators", 5'h1f, {txN, rxN, colN, polN, linkN})
    `CHK("reset mode", 7'h00, mode)
    rstn <= 1'b1;
    foreach (rows[i]) begin
      straps <= strap_type'(rows[i][12:9]);
      i_link_partner_model.setGood(rows[i][8]);
      cyc(5);
      `CHK("mode", rows[i][7:1], mode)
      `CHK("link indicator", rows[i][0], linkN)
    end
    straps <= strap_type'(4'b0100);
    for (int k = 0; k < 3; k++) begin
      i_link_partner_model.send(k, 1);
      cyc(3);
      `CHK("activity low", 1'b0, actN[k])
      cyc(10);
      i_link_partner_model.send(k, 1);
      cyc(STRETCH - 3);
      `CHK("activity retrigger", 1'b0, actN[k])
      cyc(8);
      `CHK("activity end", 1'b1, actN[k])
    end
    i_link_partner_model.send(4, 6);
    cyc(3);
    `CHK("polarity six", 1'b1, polN)
    i_link_partner_model.send(3, 1);
    i_link_partner_model.send(4, 6);
    cyc(3);
    `CHK("polarity broken run", 1'b1, polN)
    i_link_partner_model.send(4, 1);
    cyc(3);
    `CHK("polarity seven", 1'b0, polN)
    i_link_partner_model.send(3, 1);
    cyc(3);
    `CHK("polarity cleared", 1'b1, polN)
    i_link_partner_model.send(6, 2);
    cyc(3);
    `CHK("packets two", 1'b1, polN)
    axw(4'h4, 32'h8, rsp);
    `CHK("write okay", 2'h0, rsp)
    i_link_partner_model.send(6, 1);
    cyc(3);
    `CHK("packets three", 1'b0, polN)
    // registers and interrupt
    axr(4'h0, rd, rsp);
    `CHK("straps word", 4'b0100, rd[3:0])
    axr(4'h4, rd, rsp);
    `CHK("event bits", 5'h1f, rd[4:0])
    axr(4'h8, rd, rsp);
    `CHK("mask reset", 32'h0, rd)
    `CHK("read okay", 2'h0, rsp)
    axw(4'h4, 32'h1f, rsp);
    i_link_partner_model.send(1, 1);
    cyc(2);
    `CHK("irq masked", 1'b0, irq)
    axw(4'h8, 32'h2, rsp);
    cyc(2);
    `CHK("irq raised", 1'b1, irq)
    axw(4'h4, 32'h2, rsp);
    cyc(2);
    `CHK("irq cleared", 1'b0, irq)
    axr(4'hc, rd, rsp);
    `CHK("read unmapped", 2'h2, rsp)
    axw(4'hc, 32'h1, rsp);
    `CHK("write unmapped", 2'h2, rsp)
    // reset in mid stretch
    i_link_partner_model.send(0, 1);
    cyc(2);
    rstn <= 1'b0;
    cyc(2);
    `CHK("second reset", 1'b1, txN)
    rstn <= 1'b1;
    cyc(3);
    `CHK("mode after reset", 7'b0111001, mode)
    `CHK("link after reset", 1'b0, linkN)
    finish_test();
  end
endmodule // tp_media_status_indicators_test

`default_nettype wire
